/* logic/dpe_top.sv */
// PWM edge generator, output crossbar, fault gating and mode logic with APB registers.
`timescale 1ns/1ps
`include "dpe_params.svh"

// Contract
// - Output B crossbar by 4-bit select
// - Output A crossbar, same encoding, pass default
// - C-gate bit lets fault cut C
// - AB-gate bit lets fault cut A, B
// - Normal mode: bit enables cycle limiting
// - Multi/resonant: bit enables pulse matching
// - Resonant fixed duty from threshold input
// - Mode field decodes five modes
// - Coprocessor bit selects coprocessor duty path
// - Edge generator runs only when enabled
// - Edge select 0-3 own, 4-7 below
// - A switches on at selected edge
// - A switches off at selected edge
// - B switches on at selected edge
// - B switches off at selected edge
// - Loop duty readable as 18 bits
// - Counter captured at each limit event
// - Status bit shows limit fault level
module dpe_top
    import dpe_pkg::*;
#(
    parameter int DUTY_W = `DPE_DUTY_W,
    parameter int CNT_W = `DPE_CNT_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dpe_wave_t own_wave,
    input wire dpe_wave_t low_wave,
    input wire logic low_c2,
    input wire logic low_c3,
    input wire logic cycle_limit_fault,
    input wire logic [CNT_W-1:0] period_count,
    input wire logic [DUTY_W-1:0] filter_duty,
    input wire logic [DUTY_W-1:0] auto_high_threshold,
    input wire logic [DUTY_W-1:0] coprocessor_duty,
    output dpe_wave_t out_wave,
    output logic [DUTY_W-1:0] duty_out,
    output dpe_mode_t mode_out,
    output logic cycle_limit_enable,
    output logic pulse_match_enable
);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    // Read-back words are 32 bits, so wider fields could not be shown.
    if (DUTY_W < 1 || DUTY_W > 32 || CNT_W < 1 || CNT_W > 32) begin : g_bad_width
        $error("dpe_top: width parameter out of range");
    end

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    dpe_mid_cfg_t auto_config_mid;
    dpe_edge_cfg_t edge_generation_control;
    logic [CNT_W-1:0] current_limit_counter_capture;
    logic current_limit_status_bit;
    logic fault_prev;
    logic [3:0] wave_prev;
    logic edge_a;
    logic edge_b;

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    // Lane mask built from the byte strobes so partial writes keep other bytes.
    wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire sel_mid = (paddr == `DPE_ADDR_AUTO_MID);
    wire sel_edge = (paddr == `DPE_ADDR_EDGE_GEN);
    wire sel_duty = (paddr == `DPE_ADDR_DUTY_RB);
    wire sel_cap = (paddr == `DPE_ADDR_CAPTURE);
    wire sel_stat = (paddr == `DPE_ADDR_STATUS);
    wire addr_hit = sel_mid | sel_edge | sel_duty | sel_cap | sel_stat;
    wire setup_phase = psel & ~penable;
    wire wr_commit = psel & penable & pready & pwrite & ~pslverr;
    wire [31:0] wr_mask_mid = lane_mask & `DPE_MID_WMASK;
    wire [31:0] wr_mask_edge = lane_mask & `DPE_EDGE_WMASK;
    wire [31:0] next_mid = (auto_config_mid & ~wr_mask_mid) | (pwdata & wr_mask_mid);
    wire [31:0] next_edge = (edge_generation_control & ~wr_mask_edge) | (pwdata & wr_mask_edge);

    // Read mux; reserved bits are held at zero in storage, so they read zero.
    wire [31:0] rd_word =
        sel_mid ? auto_config_mid :
        sel_edge ? edge_generation_control :
        sel_duty ? 32'(filter_duty) :
        sel_cap ? 32'(current_limit_counter_capture) :
        sel_stat ? {31'h00000000, current_limit_status_bit} :
        32'h00000000;

    // Answer is prepared in the setup cycle so every bus output is a flop; no wait states.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~addr_hit;
            prdata <= (setup_phase & ~pwrite) ? rd_word : 32'h00000000;
        end
    end

    // Configuration writes land at the completing access edge.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            auto_config_mid <= `DPE_MID_RESET;
            edge_generation_control <= `DPE_EDGE_RESET;
        end else begin
            if (wr_commit && sel_mid) begin
                auto_config_mid <= next_mid;
            end
            if (wr_commit && sel_edge) begin
                edge_generation_control <= next_edge;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    // Unknown codes fall back to normal mode so the stage never runs undecoded.
    dpe_mode_t next_mode;
    always_comb begin
        case (auto_config_mid.mode)
            4'h0: next_mode = DPE_MODE_NORMAL;
            4'h1: next_mode = DPE_MODE_RESONANT;
            4'h2: next_mode = DPE_MODE_MULTI;
            4'h3: next_mode = DPE_MODE_TRIANGULAR;
            4'h4: next_mode = DPE_MODE_LEADING;
            default: next_mode = DPE_MODE_NORMAL;
        endcase
    end

    wire mode_is_normal = (next_mode == DPE_MODE_NORMAL);
    wire mode_is_reson = (next_mode == DPE_MODE_RESONANT);
    wire mode_is_multi = (next_mode == DPE_MODE_MULTI);
    wire next_limit_en = mode_is_normal & auto_config_mid.limit_match;
    wire next_match_en = (mode_is_reson | mode_is_multi) & auto_config_mid.limit_match;

    // Duty source: coprocessor first, then fixed resonant threshold, else loop filter.
    wire [DUTY_W-1:0] next_duty =
        auto_config_mid.cop_en ? coprocessor_duty :
        (mode_is_reson && auto_config_mid.fixed_duty) ? auto_high_threshold :
        filter_duty;

    // ------------------------------------------------------------------------
    // Edge generator
    // ------------------------------------------------------------------------
    // Edge vector order: own rise A, fall A, rise B, fall B, then the same below.
    wire [3:0] wave_now = {low_wave.b, low_wave.a, own_wave.b, own_wave.a};
    wire [7:0] edge_vec = {
        wave_prev[3] & ~wave_now[3], ~wave_prev[3] & wave_now[3],
        wave_prev[2] & ~wave_now[2], ~wave_prev[2] & wave_now[2],
        wave_prev[1] & ~wave_now[1], ~wave_prev[1] & wave_now[1],
        wave_prev[0] & ~wave_now[0], ~wave_prev[0] & wave_now[0]};
    wire edge_en = edge_generation_control.edge_en;
    wire a_set = edge_vec[edge_generation_control.a_on];
    wire a_clr = edge_vec[edge_generation_control.a_off];
    wire b_set = edge_vec[edge_generation_control.b_on];
    wire b_clr = edge_vec[edge_generation_control.b_off];
    // When on and off pick the same edge, off wins so the output cannot stick high.
    wire next_edge_a = edge_en & ~a_clr & (a_set | edge_a);
    wire next_edge_b = edge_en & ~b_clr & (b_set | edge_b);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wave_prev <= 4'h0;
            edge_a <= 1'b0;
            edge_b <= 1'b0;
        end else begin
            wave_prev <= wave_now;
            edge_a <= next_edge_a;
            edge_b <= next_edge_b;
        end
    end

    // ------------------------------------------------------------------------
    // Output crossbar and fault gating
    // ------------------------------------------------------------------------
    // One mux per output; codes above eight pass the module's own signal.
    function automatic logic xbar(input logic [3:0] sel, input logic own, input logic other,
                                  input logic gen);
        case (sel)
            DPE_XB_EDGE: xbar = gen;
            DPE_XB_OWN_C: xbar = own_wave.c;
            DPE_XB_CROSS: xbar = other;
            DPE_XB_LOW_A: xbar = low_wave.a;
            DPE_XB_LOW_B: xbar = low_wave.b;
            DPE_XB_LOW_C: xbar = low_wave.c;
            DPE_XB_LOW_C2: xbar = low_c2;
            DPE_XB_LOW_C3: xbar = low_c3;
            default: xbar = own;
        endcase
    endfunction : xbar

    wire mux_a = xbar(auto_config_mid.a_sel, own_wave.a, own_wave.b, edge_a);
    wire mux_b = xbar(auto_config_mid.b_sel, own_wave.b, own_wave.a, edge_b);
    // A gated output is forced low, the safe state for a power switch.
    wire cut_ab = auto_config_mid.ab_gate & cycle_limit_fault;
    wire cut_c = auto_config_mid.c_gate & cycle_limit_fault;
    wire fault_rise = cycle_limit_fault & ~fault_prev;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_wave <= '0;
            duty_out <= '0;
            mode_out <= DPE_MODE_NORMAL;
            cycle_limit_enable <= 1'b0;
            pulse_match_enable <= 1'b0;
        end else begin
            out_wave <= '{a: mux_a & ~cut_ab, b: mux_b & ~cut_ab, c: own_wave.c & ~cut_c};
            duty_out <= next_duty;
            mode_out <= next_mode;
            cycle_limit_enable <= next_limit_en;
            pulse_match_enable <= next_match_en;
        end
    end

    // ------------------------------------------------------------------------
    // Limit event capture and status
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            fault_prev <= 1'b0;
            current_limit_status_bit <= 1'b0;
            current_limit_counter_capture <= '0;
        end else begin
            fault_prev <= cycle_limit_fault;
            current_limit_status_bit <= cycle_limit_fault;
            if (fault_rise) begin
                current_limit_counter_capture <= period_count;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_b_cross_sel: assert property (
        auto_config_mid.b_sel == DPE_XB_CROSS && $stable(auto_config_mid) && !cycle_limit_fault
        |=> out_wave.b == $past(own_wave.a))
        else $error("B crossover does not carry A");
    a_a_pass_sel: assert property (
        auto_config_mid.a_sel == DPE_XB_PASS && !cut_ab |=> out_wave.a == $past(own_wave.a))
        else $error("A pass-through wrong");
    a_c_fault_cut: assert property (
        cut_c |=> !out_wave.c)
        else $error("C not cut by gated fault");
    a_ab_fault_cut: assert property (
        cut_ab |=> !out_wave.a && !out_wave.b)
        else $error("A or B not cut by gated fault");
    a_limit_mode: assert property (
        cycle_limit_enable |-> $past(mode_is_normal) && $past(auto_config_mid.limit_match))
        else $error("Limit enabled outside normal mode");
    a_match_mode: assert property (
        pulse_match_enable |-> $past(mode_is_reson || mode_is_multi)
        && $past(auto_config_mid.limit_match))
        else $error("Match enabled outside multi or resonant mode");
    a_fixed_duty: assert property (
        mode_is_reson && auto_config_mid.fixed_duty && !auto_config_mid.cop_en
        |=> duty_out == $past(auto_high_threshold))
        else $error("Fixed resonant duty not taken");
    a_cop_duty: assert property (
        auto_config_mid.cop_en |=> duty_out == $past(coprocessor_duty))
        else $error("Coprocessor duty not taken");
    a_edge_off: assert property (
        !edge_en ##1 !edge_en |-> !edge_a && !edge_b)
        else $error("Edge generator active while disabled");
    a_a_on_edge: assert property (
        edge_en && a_set && !a_clr |=> edge_a)
        else $error("A did not switch on");
    a_b_off_edge: assert property (
        b_clr |=> !edge_b)
        else $error("B did not switch off");
    a_capture_hold: assert property (
        fault_rise |=> current_limit_counter_capture == $past(period_count))
        else $error("Capture does not hold the counter value");
    a_capture_stable: assert property (
        !fault_rise |=> $stable(current_limit_counter_capture))
        else $error("Capture changed without a limit event");
    a_status_track: assert property (
        ##1 current_limit_status_bit == $past(cycle_limit_fault))
        else $error("Status does not follow fault");
    a_apb_answer: assert property (
        setup_phase ##1 (psel && penable) |-> pready && (pslverr == !$past(addr_hit)))
        else $error("APB answer wrong");

    c_edge_cycle: cover property (edge_en && a_set ##[1:20] a_clr);
    c_fault_gate: cover property (cut_ab ##1 !cut_ab);
    c_bad_addr: cover property (pready && pslverr);
    c_reson_fixed: cover property (mode_is_reson && auto_config_mid.fixed_duty);

endmodule : dpe_top

/* shared/dpe_params.svh */
// Address map, field positions and reset values of the PWM edge and configuration block.
`ifndef DPE_PARAMS_SVH
`define DPE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define DPE_ADDR_AUTO_MID 32'h001d007c
`define DPE_ADDR_EDGE_GEN 32'h001d0080
`define DPE_ADDR_DUTY_RB 32'h001d0084
`define DPE_ADDR_CAPTURE 32'h001d0088
`define DPE_ADDR_STATUS 32'h001d008c

// ----------------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------------
`define DPE_MID_WMASK 32'hff9810f2
`define DPE_EDGE_WMASK 32'h00017777
`define DPE_MID_RESET 32'h00000000
`define DPE_EDGE_RESET 32'h00000123
`define DPE_EDGE_EN_BIT 16

// ----------------------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------------------
`define DPE_DUTY_W 18
`define DPE_CNT_W 14

`endif

/* shared/dpe_pkg.sv */
// Types shared by the PWM edge and configuration block.
package dpe_pkg;

    // Crossbar choice for outputs A and B.
    typedef enum logic [3:0] {
        DPE_XB_PASS = 4'h0,
        DPE_XB_EDGE = 4'h1,
        DPE_XB_OWN_C = 4'h2,
        DPE_XB_CROSS = 4'h3,
        DPE_XB_LOW_A = 4'h4,
        DPE_XB_LOW_B = 4'h5,
        DPE_XB_LOW_C = 4'h6,
        DPE_XB_LOW_C2 = 4'h7,
        DPE_XB_LOW_C3 = 4'h8
    } dpe_xbar_sel_t;

    // Operating mode, one-hot decoded from the 4-bit field.
    typedef enum logic [4:0] {
        DPE_MODE_NORMAL = 5'h01,
        DPE_MODE_RESONANT = 5'h02,
        DPE_MODE_MULTI = 5'h04,
        DPE_MODE_TRIANGULAR = 5'h08,
        DPE_MODE_LEADING = 5'h10
    } dpe_mode_t;

    // Layout of the auto configuration register.
    typedef struct packed {
        logic [3:0] b_sel;
        logic [3:0] a_sel;
        logic c_gate;
        logic [1:0] rsv22;
        logic ab_gate;
        logic limit_match;
        logic [5:0] rsv13;
        logic fixed_duty;
        logic [3:0] rsv8;
        logic [3:0] mode;
        logic [1:0] rsv2;
        logic cop_en;
        logic rsv0;
    } dpe_mid_cfg_t;

    // Layout of the edge generation register.
    typedef struct packed {
        logic [14:0] rsv17;
        logic edge_en;
        logic rsv15;
        logic [2:0] a_on;
        logic rsv11;
        logic [2:0] a_off;
        logic rsv7;
        logic [2:0] b_on;
        logic rsv3;
        logic [2:0] b_off;
    } dpe_edge_cfg_t;

    // Waveforms of one PWM module.
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } dpe_wave_t;

endpackage : dpe_pkg

/* sim/dpe_partner.sv */
// Model of the neighbouring modules, loop filter and period counter around the block.
`timescale 1ns/1ps
module dpe_partner
    import dpe_pkg::*;
#(
    parameter logic [17:0] FILTER_VAL = 18'h2b3c5,
    parameter logic [17:0] HIGH_VAL = 18'h1a0f7,
    parameter logic [17:0] COP_VAL = 18'h0d1e9
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] wave_cmd,
    input wire logic fault_cmd,
    input wire logic [13:0] cnt_cmd,
    output dpe_wave_t own_wave,
    output dpe_wave_t low_wave,
    output logic low_c2,
    output logic low_c3,
    output logic cycle_limit_fault,
    output logic [13:0] period_count,
    output logic [17:0] filter_duty,
    output logic [17:0] auto_high_threshold,
    output logic [17:0] coprocessor_duty
);
    // Sources change just after an edge, as the neighbouring modules do.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {own_wave, low_wave, low_c2, low_c3} <= 8'h00;
            cycle_limit_fault <= 1'b0;
            period_count <= 14'h0000;
        end else begin
            {own_wave, low_wave, low_c2, low_c3} <= wave_cmd;
            cycle_limit_fault <= fault_cmd;
            period_count <= cnt_cmd;
        end
    end

    // Distinct duty sources, so a wrong selection cannot pass unseen.
    assign filter_duty = FILTER_VAL;
    assign auto_high_threshold = HIGH_VAL;
    assign coprocessor_duty = COP_VAL;
endmodule : dpe_partner

/* sim/testbench.sv */
// Self-checking bench for the PWM edge and configuration block.
`timescale 1ns/1ps
`include "dpe_params.svh"
module testbench
    import dpe_pkg::*;
;
    localparam logic [17:0] FV = 18'h2b3c5;
    localparam logic [17:0] HV = 18'h1a0f7;
    localparam logic [17:0] CV = 18'h0d1e9;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    dpe_wave_t own_wave, low_wave, out_wave;
    logic low_c2, low_c3, cycle_limit_fault, cycle_limit_enable, pulse_match_enable, fault_cmd;
    logic [13:0] period_count, cnt_cmd;
    logic [17:0] filter_duty, auto_high_threshold, coprocessor_duty, duty_out;
    dpe_mode_t mode_out;
    logic [7:0] wave_cmd;
    int fail_count = 0;
    int n_tests = 0;

    dpe_top i_dpe_top (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .own_wave(own_wave), .low_wave(low_wave),
        .low_c2(low_c2), .low_c3(low_c3), .cycle_limit_fault(cycle_limit_fault),
        .period_count(period_count), .filter_duty(filter_duty),
        .auto_high_threshold(auto_high_threshold), .coprocessor_duty(coprocessor_duty),
        .out_wave(out_wave), .duty_out(duty_out), .mode_out(mode_out),
        .cycle_limit_enable(cycle_limit_enable), .pulse_match_enable(pulse_match_enable));
    dpe_partner #(.FILTER_VAL(FV), .HIGH_VAL(HV), .COP_VAL(CV)) i_dpe_partner (
        .core_clk(core_clk), .rstn(rstn), .wave_cmd(wave_cmd), .fault_cmd(fault_cmd),
        .cnt_cmd(cnt_cmd), .own_wave(own_wave), .low_wave(low_wave), .low_c2(low_c2),
        .low_c3(low_c3), .cycle_limit_fault(cycle_limit_fault), .period_count(period_count),
        .filter_duty(filter_duty), .auto_high_threshold(auto_high_threshold),
        .coprocessor_duty(coprocessor_duty));

    // Free-running 200 MHz clock.
    always #2.5 core_clk = ~core_clk;

    // --------------------
    // Shared tasks
    // --------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // One APB transfer; the wait on pready is bounded so a dead slave ends the run.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check(32'(err), 32'(experr));
    endtask : rdchk

    // Expected crossbar output; v holds own a,b,c, lower a,b,c, level-2 C, level-3 C.
    function automatic logic xb_exp(input logic [3:0] c, input logic [7:0] v, input logic b);
        if (c == 4'h1) return 1'b0;
        if (c == 4'h2) return v[5];
        if (c == 4'h3) return b ? v[7] : v[6];
        if (c >= 4'h4 && c <= 4'h8) return v[4'h8 - c];
        return b ? v[6] : v[7];
    endfunction : xb_exp

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_regs();
        check(32'(mode_out), 32'h1);
        rdchk(`DPE_ADDR_AUTO_MID, 32'h0, 1'b0);
        rdchk(`DPE_ADDR_EDGE_GEN, 32'h00000123, 1'b0);
        wr(`DPE_ADDR_AUTO_MID, 32'hffffffff);
        rdchk(`DPE_ADDR_AUTO_MID, 32'hff9810f2, 1'b0);
        pstrb <= 4'h8;
        wr(`DPE_ADDR_AUTO_MID, 32'h0);
        pstrb <= 4'hf;
        rdchk(`DPE_ADDR_AUTO_MID, 32'h009810f2, 1'b0);
        wr(`DPE_ADDR_EDGE_GEN, 32'hffffffff);
        rdchk(`DPE_ADDR_EDGE_GEN, 32'h00017777, 1'b0);
        wr(`DPE_ADDR_DUTY_RB, 32'h0);
        rdchk(`DPE_ADDR_DUTY_RB, 32'(FV), 1'b0);
        rdchk(32'h001d0090, 32'h0, 1'b1);
        wr(`DPE_ADDR_AUTO_MID, 32'h0);
        wr(`DPE_ADDR_EDGE_GEN, 32'h00000123);
    endtask : t_regs

    task automatic t_xbar();
        logic [7:0] v;
        for (int c = 0; c < 10; c++) begin
            wr(`DPE_ADDR_AUTO_MID, {c[3:0], c[3:0], 24'h0});
            for (int k = 0; k < 8; k++) begin
                v = 8'h01 << k;
                wave_cmd <= v;
                tick(4);
                check(32'(out_wave.a), 32'(xb_exp(c[3:0], v, 1'b0)));
                check(32'(out_wave.b), 32'(xb_exp(c[3:0], v, 1'b1)));
                check(32'(out_wave.c), 32'(v[5]));
            end
        end
        wave_cmd <= 8'h00;
    endtask : t_xbar

    // Each source edge in turn switches A on and B off and its opposite edge undoes it; the signal always rises first.
    // Even codes run before odd ones, so the outputs flip at almost every check.
    task automatic t_edge();
        logic [2:0] s;
        wr(`DPE_ADDR_AUTO_MID, 32'h11000000);
        for (int i = 0; i < 8; i++) begin
            s = {i[1:0], i[2]};
            wr(`DPE_ADDR_EDGE_GEN, {16'h1, 1'b0, s, 1'b0, s ^ 3'h1, 1'b0, s ^ 3'h1, 1'b0, s});
            tick(2);
            wave_cmd <= 8'h80 >> (s[1] + (s[2] ? 3 : 0));
            tick(4);
            check(32'(out_wave.a), 32'(!s[0]));
            check(32'(out_wave.b), 32'(s[0]));
            wave_cmd <= 8'h00;
            tick(4);
            check(32'(out_wave.a), 32'(s[0]));
            check(32'(out_wave.b), 32'(!s[0]));
        end
        wr(`DPE_ADDR_EDGE_GEN, 32'h00000123);
        tick(3);
        check(32'(out_wave.a), 32'h0);
    endtask : t_edge

    task automatic t_fault();
        wave_cmd <= 8'he0;
        cnt_cmd <= 14'h2a5c;
        wr(`DPE_ADDR_AUTO_MID, 32'h00180000);
        fault_cmd <= 1'b1;
        tick(4);
        check(32'(out_wave), 32'h1);
        check(32'(cycle_limit_enable), 32'h1);
        cnt_cmd <= 14'h0777;
        rdchk(`DPE_ADDR_CAPTURE, 32'h2a5c, 1'b0);
        rdchk(`DPE_ADDR_STATUS, 32'h1, 1'b0);
        fault_cmd <= 1'b0;
        tick(4);
        check(32'(out_wave), 32'h7);
        fault_cmd <= 1'b1;
        wr(`DPE_ADDR_AUTO_MID, 32'h00800000);
        tick(3);
        check(32'(out_wave), 32'h6);
        check(32'(cycle_limit_enable), 32'h0);
        rdchk(`DPE_ADDR_CAPTURE, 32'h0777, 1'b0);
        fault_cmd <= 1'b0;
        tick(4);
        rdchk(`DPE_ADDR_STATUS, 32'h0, 1'b0);
    endtask : t_fault

    // Mode codes 0 to 5, with fixed duty and coprocessor bits in all four combinations.
    task automatic t_mode();
        logic [4:0] em;
        for (int m = 0; m < 6; m++) begin
            for (int f = 0; f < 4; f++) begin
                wr(`DPE_ADDR_AUTO_MID, {13'h1, 6'h0, f[0], 4'h0, m[3:0], 2'h0, f[1], 1'b0});
                tick(3);
                em = (m < 5) ? 5'h01 << m : 5'h01;
                check(32'(mode_out), 32'(em));
                check(32'(cycle_limit_enable), 32'(em == 5'h01));
                check(32'(pulse_match_enable), 32'(em == 5'h02 || em == 5'h04));
                check(32'(duty_out), 32'(f[1] ? CV : (f[0] && m == 1) ? HV : FV));
            end
        end
        wr(`DPE_ADDR_AUTO_MID, 32'h00000020);
        tick(3);
        check(32'(pulse_match_enable), 32'h0);
    endtask : t_mode

    // Reset for five cycles, then run every scenario and report.
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        {psel, penable, pwrite, fault_cmd} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        wave_cmd = 8'h00;
        cnt_cmd = 14'h0000;
        tick(5);
        rstn <= 1'b1;
        tick(1);
        t_regs();
        t_xbar();
        t_edge();
        t_fault();
        t_mode();
        complete_run();
    end
endmodule : testbench
